// ===== src/dif_pkg.sv
package dif_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] DIF_OFS_SEL_LO = 8'h00;
  localparam logic [7:0] DIF_OFS_SEL_HI = 8'h04;
  localparam logic [7:0] DIF_OFS_CTRL = 8'h08;
  localparam logic [7:0] DIF_OFS_LIMITS = 8'h0c;
  localparam logic [7:0] DIF_OFS_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] DIF_RST_SEL_LO = 32'h0000_0000;
  localparam logic [15:0] DIF_RST_SEL_HI = 16'h0000;
  localparam logic [7:0] DIF_RST_FREQ_SRC = 8'h00;
  localparam logic [15:0] DIF_RST_TIMER_PERIOD = 16'h000a;
  localparam logic [15:0] DIF_RST_UPPER = 16'h1770;
  localparam logic [15:0] DIF_RST_LOWER = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DIF_CTRL_PERIOD_LSB = 16;
  localparam int DIF_LIMITS_LOWER_LSB = 16;
  localparam int DIF_STATUS_LATCH1 = 6;
  localparam int DIF_STATUS_LATCH2 = 7;
  localparam int DIF_STATUS_TIMER = 8;
  localparam int DIF_STATUS_UD_LSB = 16;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DIF_CLK_MHZ = 100;
  localparam int DIF_SCAN_PERIOD_US = 5000;
  localparam int DIF_SCAN_CYCLES = DIF_SCAN_PERIOD_US * DIF_CLK_MHZ;
  localparam int DIF_TICK_PERIOD_MS = 100;
  localparam int DIF_TICK_CYCLES = DIF_TICK_PERIOD_MS * 1000 * DIF_CLK_MHZ;

  // ----------------------------------------------------------------
  // function-select codes
  // ----------------------------------------------------------------
  localparam logic [7:0] DIF_PANEL_FREQ_SRC = 8'h08;
  localparam int DIF_MAX_CODE = 99;
  localparam int DIF_EMERGENCY_STOP = 1;
  localparam int DIF_PRESET_THREE = 2;
  localparam int DIF_PRESET_TWO = 3;
  localparam int DIF_PRESET_ONE = 4;
  localparam int DIF_JOG_SPEED = 5;
  localparam int DIF_OVERHEAT = 6;
  localparam int DIF_TIMER_A = 7;
  localparam int DIF_BLOCK_ACTIVE = 8;
  localparam int DIF_FWD_JOG = 9;
  localparam int DIF_REV_JOG = 10;
  localparam int DIF_TIMER_B = 11;
  localparam int DIF_UD_CLEAR = 15;
  localparam int DIF_UD_LOAD = 16;
  localparam int DIF_UD_HOLD = 17;
  localparam int DIF_BLOCK_INACTIVE = 18;
  localparam int DIF_UD_UP = 19;
  localparam int DIF_UD_DOWN = 20;
  localparam int DIF_ALARM_CLEAR = 21;
  localparam int DIF_SET1 = 22;
  localparam int DIF_CLR1 = 23;
  localparam int DIF_SET2 = 24;
  localparam int DIF_CLR2 = 25;
  localparam int DIF_SET_BOTH = 26;
  localparam int DIF_CLR_BOTH = 27;
  localparam int DIF_TIMER_CLK = 28;
  localparam int DIF_OVERHEAT_OPEN = 30;
  localparam int DIF_AUTO_SW = 31;
  localparam int DIF_TIMER_C = 36;
  localparam int DIF_BRAKE1 = 69;
  localparam int DIF_BRAKE2 = 70;
  localparam int DIF_BRAKE3 = 71;
  localparam int DIF_SENSORLESS = 72;
  localparam int DIF_RUN = 73;
  localparam int DIF_REVERSE = 74;
  localparam int DIF_POWER_SEL = 75;
  localparam int DIF_PANEL_UP = 78;
  localparam int DIF_PANEL_DOWN = 79;
  localparam int DIF_SPEED_SW = 88;
  localparam int DIF_CTRL_SW = 89;
  localparam int DIF_BOTH_SW = 90;
  localparam int DIF_TIMER_A_INV = 91;
  localparam int DIF_TIMER_B_INV = 92;
  localparam int DIF_TIMER_C_INV = 93;
  localparam int DIF_SCALED_A = 94;
  localparam int DIF_SCALED_B = 95;
  localparam int DIF_SCALED_C = 96;
  localparam int DIF_SCALED_A_INV = 97;
  localparam int DIF_SCALED_B_INV = 98;
  localparam int DIF_SCALED_C_INV = 99;

  typedef enum logic [1:0] {
    DIF_TMR_OFF = 2'b00,
    DIF_TMR_A = 2'b01,
    DIF_TMR_B = 2'b10,
    DIF_TMR_C = 2'b11
  } dif_tmr_mode_e;
endpackage : dif_pkg

// ===== src/dif_top.sv
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module dif_top
  import dif_pkg::*;
#(
  parameter int SCAN_CYCLES = dif_pkg::DIF_SCAN_CYCLES,
  parameter int TICK_CYCLES = dif_pkg::DIF_TICK_CYCLES,
  parameter int NUM_INPUTS = 6
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // terminals, low when tied to the common return
  input wire logic [NUM_INPUTS-1:0] MULTI_FUNCTION_INPUT_N,
  // drive state
  input wire logic ALARM_PENDING,
  input wire logic [7:0] ANALOG_INPUT_TWO,
  // function requests
  output logic EMERGENCY_STOP,
  output logic PRESET_SPEED_ONE,
  output logic PRESET_SPEED_TWO,
  output logic PRESET_SPEED_THREE,
  output logic JOG_SPEED,
  output logic OVERHEAT_TRIP,
  output logic FORWARD_JOG_RUN,
  output logic REVERSE_JOG_RUN,
  output logic OUTPUT_BLOCK,
  output logic ALARM_CLEAR,
  output logic LATCH_ONE,
  output logic LATCH_TWO,
  output logic TIMER_OUTPUT,
  output logic AUTO_RUN_SELECT,
  output logic DC_BRAKE,
  output logic [1:0] DC_BRAKE_SOURCE,
  output logic SENSORLESS_SELECT,
  output logic RUN_COMMAND,
  output logic REVERSE_COMMAND,
  output logic POWER_CONTROL_AI3,
  output logic PANEL_FREQ_UP,
  output logic PANEL_FREQ_DOWN,
  output logic SPEED_SOURCE_SW,
  output logic CONTROL_SOURCE_SW,
  output logic [15:0] UD_COUNT
);
  import dif_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] sel_lo;
  logic [15:0] sel_hi;
  logic [7:0] frequency_source_select;
  logic [15:0] timer_period_setting;
  logic [15:0] upper_frequency_limit;
  logic [15:0] lower_frequency_limit;
  logic [7:0] sel [0:NUM_INPUTS-1];
  logic [NUM_INPUTS-1:0] active;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] acc_addr;

  assign sel[0] = sel_lo[7:0];
  assign sel[1] = sel_lo[15:8];
  assign sel[2] = sel_lo[23:16];
  assign sel[3] = sel_lo[31:24];
  assign sel[4] = sel_hi[7:0];
  assign sel[5] = sel_hi[15:8];

  wire addr_ok = HSEL & HTRANS[1] & HREADY;

  // writes are zero-wait; reads take one wait state so that a read
  // straight after a write to the same word sees the new value
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_addr <= 8'h00;
      HREADYOUT <= 1'b1;
    end else begin
      wr_pend <= addr_ok & HWRITE;
      rd_pend <= addr_ok & ~HWRITE;
      if (addr_ok) begin
        acc_addr <= {HADDR[7:2], 2'b00};
      end
      HREADYOUT <= ~(addr_ok & ~HWRITE);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sel_lo <= DIF_RST_SEL_LO;
      sel_hi <= DIF_RST_SEL_HI;
      frequency_source_select <= DIF_RST_FREQ_SRC;
      timer_period_setting <= DIF_RST_TIMER_PERIOD;
      upper_frequency_limit <= DIF_RST_UPPER;
      lower_frequency_limit <= DIF_RST_LOWER;
    end else if (wr_pend) begin
      case (acc_addr)
        DIF_OFS_SEL_LO: sel_lo <= HWDATA;
        DIF_OFS_SEL_HI: sel_hi <= HWDATA[15:0];
        DIF_OFS_CTRL: begin
          frequency_source_select <= HWDATA[7:0];
          timer_period_setting <= HWDATA[DIF_CTRL_PERIOD_LSB +: 16];
        end
        DIF_OFS_LIMITS: begin
          upper_frequency_limit <= HWDATA[15:0];
          lower_frequency_limit <= HWDATA[DIF_LIMITS_LOWER_LSB +: 16];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_pend) begin
      case (acc_addr)
        DIF_OFS_SEL_LO: HRDATA <= sel_lo;
        DIF_OFS_SEL_HI: HRDATA <= {16'h0000, sel_hi};
        DIF_OFS_CTRL: HRDATA <= {timer_period_setting, 8'h00, frequency_source_select};
        DIF_OFS_LIMITS: HRDATA <= {lower_frequency_limit, upper_frequency_limit};
        DIF_OFS_STATUS: HRDATA <= {UD_COUNT, 7'h00, TIMER_OUTPUT, LATCH_TWO, LATCH_ONE,
          active};
        default: HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      HRESP <= 1'b0;
    end else begin
      HRESP <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // terminal sampling
  // ----------------------------------------------------------------
  logic [NUM_INPUTS-1:0] pin_meta;
  logic [NUM_INPUTS-1:0] pin_sync;
  logic [31:0] scan_cnt;
  logic scan_tick;
  logic [31:0] tick_cnt;
  logic base_tick;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pin_meta <= '1;
      pin_sync <= '1;
    end else begin
      pin_meta <= MULTI_FUNCTION_INPUT_N;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      scan_cnt <= 32'h0000_0000;
      scan_tick <= 1'b0;
    end else begin
      scan_tick <= (scan_cnt == 32'(SCAN_CYCLES - 1));
      scan_cnt <= (scan_cnt == 32'(SCAN_CYCLES - 1)) ? 32'h0000_0000 : scan_cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      active <= '0;
    end else if (scan_tick) begin
      active <= ~pin_sync;
    end
  end

  // 0.1 s time base for the timer block
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      tick_cnt <= 32'h0000_0000;
      base_tick <= 1'b0;
    end else begin
      base_tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------
  // everything the decode reads is an argument, so every assign that calls it
  // wakes up when a select or a sampled level moves
  function automatic logic code_hit(input logic [NUM_INPUTS-1:0] match,
    input logic [NUM_INPUTS-1:0] lvl, input logic level);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (match[i] && lvl[i] == level) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : code_hit

  logic [DIF_MAX_CODE:0] on_hit;
  logic [DIF_MAX_CODE:0] off_hit;

  // code 0 and every code below left out of the outputs never act
  assign on_hit[0] = 1'b0;
  assign off_hit[0] = 1'b0;
  generate
    for (genvar c = 1; c <= DIF_MAX_CODE; c++) begin : g_code
      logic [NUM_INPUTS-1:0] match;
      for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
        assign match[i] = (sel[i] == 8'(c));
      end
      assign on_hit[c] = code_hit(match, active, 1'b1);
      assign off_hit[c] = code_hit(match, active, 1'b0);
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      EMERGENCY_STOP <= 1'b0;
      PRESET_SPEED_ONE <= 1'b0;
      PRESET_SPEED_TWO <= 1'b0;
      PRESET_SPEED_THREE <= 1'b0;
      JOG_SPEED <= 1'b0;
      OVERHEAT_TRIP <= 1'b0;
      FORWARD_JOG_RUN <= 1'b0;
      REVERSE_JOG_RUN <= 1'b0;
      OUTPUT_BLOCK <= 1'b0;
      ALARM_CLEAR <= 1'b0;
      AUTO_RUN_SELECT <= 1'b0;
      SENSORLESS_SELECT <= 1'b0;
      RUN_COMMAND <= 1'b0;
      REVERSE_COMMAND <= 1'b0;
      POWER_CONTROL_AI3 <= 1'b0;
      PANEL_FREQ_UP <= 1'b0;
      PANEL_FREQ_DOWN <= 1'b0;
      SPEED_SOURCE_SW <= 1'b0;
      CONTROL_SOURCE_SW <= 1'b0;
    end else begin
      EMERGENCY_STOP <= on_hit[DIF_EMERGENCY_STOP];
      PRESET_SPEED_THREE <= on_hit[DIF_PRESET_THREE];
      PRESET_SPEED_TWO <= on_hit[DIF_PRESET_TWO];
      PRESET_SPEED_ONE <= on_hit[DIF_PRESET_ONE];
      JOG_SPEED <= on_hit[DIF_JOG_SPEED];
      OVERHEAT_TRIP <= on_hit[DIF_OVERHEAT] | off_hit[DIF_OVERHEAT_OPEN];
      FORWARD_JOG_RUN <= on_hit[DIF_FWD_JOG];
      REVERSE_JOG_RUN <= on_hit[DIF_REV_JOG];
      OUTPUT_BLOCK <= on_hit[DIF_BLOCK_ACTIVE] | off_hit[DIF_BLOCK_INACTIVE];
      ALARM_CLEAR <= on_hit[DIF_ALARM_CLEAR] & ALARM_PENDING;
      AUTO_RUN_SELECT <= on_hit[DIF_AUTO_SW];
      SENSORLESS_SELECT <= on_hit[DIF_SENSORLESS];
      RUN_COMMAND <= on_hit[DIF_RUN];
      REVERSE_COMMAND <= on_hit[DIF_REVERSE];
      POWER_CONTROL_AI3 <= on_hit[DIF_POWER_SEL];
      PANEL_FREQ_UP <= on_hit[DIF_PANEL_UP] &
        (frequency_source_select == DIF_PANEL_FREQ_SRC);
      PANEL_FREQ_DOWN <= on_hit[DIF_PANEL_DOWN] &
        (frequency_source_select == DIF_PANEL_FREQ_SRC);
      SPEED_SOURCE_SW <= on_hit[DIF_SPEED_SW] | on_hit[DIF_BOTH_SW];
      CONTROL_SOURCE_SW <= on_hit[DIF_CTRL_SW] | on_hit[DIF_BOTH_SW];
    end
  end

  // lowest-numbered brake code wins when several ask at once
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      DC_BRAKE <= 1'b0;
      DC_BRAKE_SOURCE <= 2'h0;
    end else begin
      DC_BRAKE <= on_hit[DIF_BRAKE1] | on_hit[DIF_BRAKE2] | on_hit[DIF_BRAKE3];
      if (on_hit[DIF_BRAKE1]) begin
        DC_BRAKE_SOURCE <= 2'h0;
      end else if (on_hit[DIF_BRAKE2]) begin
        DC_BRAKE_SOURCE <= 2'h1;
      end else if (on_hit[DIF_BRAKE3]) begin
        DC_BRAKE_SOURCE <= 2'h2;
      end
    end
  end

  // ----------------------------------------------------------------
  // latches and up/down counter
  // ----------------------------------------------------------------
  wire set_one = on_hit[DIF_SET1] | on_hit[DIF_SET_BOTH];
  wire clr_one = on_hit[DIF_CLR1] | on_hit[DIF_CLR_BOTH];
  wire set_two = on_hit[DIF_SET2] | on_hit[DIF_SET_BOTH];
  wire clr_two = on_hit[DIF_CLR2] | on_hit[DIF_CLR_BOTH];

  // set beats clear when both are asserted
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LATCH_ONE <= 1'b0;
      LATCH_TWO <= 1'b0;
    end else begin
      LATCH_ONE <= set_one | (LATCH_ONE & ~clr_one);
      LATCH_TWO <= set_two | (LATCH_TWO & ~clr_two);
    end
  end

  // one step per scan; the ramp rate itself belongs to the drive
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      UD_COUNT <= DIF_RST_LOWER;
    end else if (scan_tick) begin
      if (on_hit[DIF_UD_CLEAR]) begin
        UD_COUNT <= lower_frequency_limit;
      end else if (on_hit[DIF_UD_LOAD]) begin
        UD_COUNT <= upper_frequency_limit;
      end else if (on_hit[DIF_UD_HOLD]) begin
        UD_COUNT <= UD_COUNT;
      end else if (on_hit[DIF_UD_UP] && !on_hit[DIF_UD_DOWN]) begin
        if (UD_COUNT < upper_frequency_limit) begin
          UD_COUNT <= UD_COUNT + 16'h1;
        end
      end else if (on_hit[DIF_UD_DOWN] && !on_hit[DIF_UD_UP]) begin
        if (UD_COUNT > lower_frequency_limit) begin
          UD_COUNT <= UD_COUNT - 16'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // shared timer/counter block
  // ----------------------------------------------------------------
  function automatic logic assigned(input logic [DIF_MAX_CODE:0] used, input int a,
    input int b, input int c, input int d);
    return used[a] | used[b] | used[c] | used[d];
  endfunction : assigned

  wire trig_a = on_hit[DIF_TIMER_A] | off_hit[DIF_TIMER_A_INV] | on_hit[DIF_SCALED_A] |
    off_hit[DIF_SCALED_A_INV];
  wire trig_b = on_hit[DIF_TIMER_B] | off_hit[DIF_TIMER_B_INV] | on_hit[DIF_SCALED_B] |
    off_hit[DIF_SCALED_B_INV];
  wire trig_c = on_hit[DIF_TIMER_C] | off_hit[DIF_TIMER_C_INV] | on_hit[DIF_SCALED_C] |
    off_hit[DIF_SCALED_C_INV];
  wire scaled = |(on_hit[DIF_SCALED_C_INV:DIF_SCALED_A] |
    off_hit[DIF_SCALED_C_INV:DIF_SCALED_A]);
  wire counter_mode = on_hit[DIF_TIMER_CLK] | off_hit[DIF_TIMER_CLK];
  wire [DIF_MAX_CODE:0] code_used = on_hit | off_hit;

  dif_tmr_mode_e tmr_mode;
  logic tmr_trig;
  logic trig_prev;
  logic clk_prev;
  logic [23:0] tmr_cnt;
  logic [23:0] tmr_target;
  logic tmr_step;

  // only one timer type can own the block; A beats B beats C
  always_comb begin
    tmr_mode = DIF_TMR_OFF;
    tmr_trig = 1'b0;
    if (assigned(code_used, DIF_TIMER_A, DIF_TIMER_A_INV, DIF_SCALED_A,
        DIF_SCALED_A_INV)) begin
      tmr_mode = DIF_TMR_A;
      tmr_trig = trig_a;
    end else if (assigned(code_used, DIF_TIMER_B, DIF_TIMER_B_INV, DIF_SCALED_B,
        DIF_SCALED_B_INV)) begin
      tmr_mode = DIF_TMR_B;
      tmr_trig = trig_b;
    end else if (assigned(code_used, DIF_TIMER_C, DIF_TIMER_C_INV, DIF_SCALED_C,
        DIF_SCALED_C_INV)) begin
      tmr_mode = DIF_TMR_C;
      tmr_trig = trig_c;
    end
  end

  assign tmr_target = scaled ? (24'(timer_period_setting) * 24'(ANALOG_INPUT_TWO)) :
    24'(timer_period_setting);
  // counter mode swaps the time base for edges on the clock input
  assign tmr_step = counter_mode ? (on_hit[DIF_TIMER_CLK] & ~clk_prev) : base_tick;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      clk_prev <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      clk_prev <= on_hit[DIF_TIMER_CLK];
      trig_prev <= tmr_trig;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      TIMER_OUTPUT <= 1'b0;
      tmr_cnt <= 24'h00_0000;
    end else begin
      case (tmr_mode)
        DIF_TMR_A: begin
          if (tmr_trig) begin
            TIMER_OUTPUT <= 1'b1;
            tmr_cnt <= 24'h00_0000;
          end else if (TIMER_OUTPUT) begin
            if (tmr_cnt >= tmr_target) begin
              TIMER_OUTPUT <= 1'b0;
            end else if (tmr_step) begin
              tmr_cnt <= tmr_cnt + 24'h1;
            end
          end
        end
        DIF_TMR_B: begin
          if (!tmr_trig) begin
            TIMER_OUTPUT <= 1'b0;
            tmr_cnt <= 24'h00_0000;
          end else if (tmr_cnt >= tmr_target) begin
            TIMER_OUTPUT <= 1'b1;
          end else if (tmr_step) begin
            tmr_cnt <= tmr_cnt + 24'h1;
          end
        end
        DIF_TMR_C: begin
          if (tmr_trig && !trig_prev) begin
            TIMER_OUTPUT <= 1'b1;
            tmr_cnt <= 24'h00_0000;
          end else if (TIMER_OUTPUT) begin
            if (tmr_cnt >= tmr_target) begin
              TIMER_OUTPUT <= 1'b0;
            end else if (tmr_step) begin
              tmr_cnt <= tmr_cnt + 24'h1;
            end
          end
        end
        default: begin
          TIMER_OUTPUT <= 1'b0;
          tmr_cnt <= 24'h00_0000;
        end
      endcase
    end
  end
endmodule : dif_top

// ===== test/dif_contacts.sv
`timescale 1ns/1ns
module dif_contacts #(
  parameter int N = 6
) (
  // contact requests from the bench
  input wire logic [N-1:0] closed,
  // terminal pins
  output logic [N-1:0] pin_n
);
  // an open contact floats to the pull-up, a closed one shorts to the common return
  assign pin_n = ~closed;
endmodule : dif_contacts

// ===== test/dif_top_sva.sv
`timescale 1ns/1ns
module dif_top_sva (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic HRESP,
  // functions
  input wire logic ALARM_PENDING,
  input wire logic ALARM_CLEAR,
  input wire logic DC_BRAKE,
  input wire logic [1:0] DC_BRAKE_SOURCE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic rd_take;
  logic wr_take;
  assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
  assign wr_take = HSEL && HTRANS[1] && HREADY && HWRITE;
  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  chk_read_wait: assert property (rd_take |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_take |=> HREADYOUT)
    else $error("write stalled");
  chk_wait_cause: assert property ($fell(HREADYOUT) |-> $past(rd_take))
    else $error("wait without read");
  chk_wait_single: assert property (!HREADYOUT |=> $rose(HREADYOUT))
    else $error("wait longer than one cycle");
  chk_rdata_hold: assert property ($changed(HRDATA) |-> $rose(HREADYOUT))
    else $error("read data moved outside a read");
  chk_alarm_gate: assert property (ALARM_CLEAR |-> $past(ALARM_PENDING))
    else $error("alarm clear without alarm");
  chk_brake_source: assert property (DC_BRAKE |-> DC_BRAKE_SOURCE != 2'b11)
    else $error("brake source out of range");
endmodule : dif_top_sva
bind dif_top dif_top_sva u_sva (.CLK, .RSTN, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT,
  .HRDATA, .HRESP, .ALARM_PENDING, .ALARM_CLEAR, .DC_BRAKE, .DC_BRAKE_SOURCE);

// ===== test/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
  import dif_pkg::*;
  localparam int SC = 20;
  logic CLK = 0, RSTN = 0, HSEL = 0, HWRITE = 0, ALARM_PENDING = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd;
  logic [1:0] HTRANS = 0, DC_BRAKE_SOURCE;
  logic [7:0] ANALOG_INPUT_TWO = 8'h01;
  logic [5:0] closed = 0, MULTI_FUNCTION_INPUT_N;
  logic [15:0] UD_COUNT;
  logic HREADYOUT, HRESP, EMERGENCY_STOP, PRESET_SPEED_ONE, PRESET_SPEED_TWO;
  logic PRESET_SPEED_THREE, JOG_SPEED, OVERHEAT_TRIP, FORWARD_JOG_RUN, REVERSE_JOG_RUN;
  logic OUTPUT_BLOCK, ALARM_CLEAR, LATCH_ONE, LATCH_TWO, TIMER_OUTPUT, AUTO_RUN_SELECT;
  logic DC_BRAKE, SENSORLESS_SELECT, RUN_COMMAND, REVERSE_COMMAND, POWER_CONTROL_AI3;
  logic PANEL_FREQ_UP, PANEL_FREQ_DOWN, SPEED_SOURCE_SW, CONTROL_SOURCE_SW;
  wire logic HREADY;
  int bad_count = 0, samples_checked = 0;
  logic [16:0] fv;
  logic [7:0] codes [22] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0a, 8'h08,
    8'h1f, 8'h45, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h58, 8'h59, 8'h12, 8'h1e, 8'h00, 8'h0c, 8'h5a};
  logic [16:0] ecx [5] = '{17'h0, 17'h0, 17'h0, 17'h0, 17'h18000};
  logic [16:0] eox [5] = '{17'h00100, 17'h00020, 17'h0, 17'h0, 17'h0};
  assign HREADY = HREADYOUT;
  assign fv = {CONTROL_SOURCE_SW, SPEED_SOURCE_SW, POWER_CONTROL_AI3, REVERSE_COMMAND,
    RUN_COMMAND, SENSORLESS_SELECT, DC_BRAKE, AUTO_RUN_SELECT, OUTPUT_BLOCK, REVERSE_JOG_RUN,
    FORWARD_JOG_RUN, OVERHEAT_TRIP, JOG_SPEED, PRESET_SPEED_ONE, PRESET_SPEED_TWO,
    PRESET_SPEED_THREE, EMERGENCY_STOP};
  always #5 CLK = ~CLK;
  dif_top #(.SCAN_CYCLES(SC), .TICK_CYCLES(8)) dut (.*);
  dif_contacts u_contacts (.closed(closed), .pin_n(MULTI_FUNCTION_INPUT_N));
  // ----------------------------------------------------------------
  // bus and timing helpers
  // ----------------------------------------------------------------
  // ready and read data are taken at the rising edge that samples ready high
  task wait_rdy;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    rd = HRDATA;
  endtask : wait_rdy
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    wait_rdy;
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    wait_rdy;
  endtask : bus
  // two full scans plus the synchroniser
  task settle;
    repeat (2 * SC + 6) @(posedge CLK);
  endtask : settle
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    `CHK("reset functions", 17'h0, fv)
    bus(1'b0, DIF_OFS_CTRL, 32'h0);
    `CHK("ctrl", {DIF_RST_TIMER_PERIOD, 8'h00, DIF_RST_FREQ_SRC}, rd)
    bus(1'b0, DIF_OFS_LIMITS, 32'h0);
    `CHK("limits", {DIF_RST_LOWER, DIF_RST_UPPER}, rd)
    bus(1'b1, 8'h40, 32'h1234_5678);
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, DIF_OFS_SEL_HI, 32'h0000_0100);
    bus(1'b0, DIF_OFS_SEL_HI, 32'h0);
    `CHK("sel hi", 32'h0000_0100, rd)
  endtask : t_regs
  task t_codes;
    for (int i = 0; i < 22; i++) begin
      bus(1'b1, DIF_OFS_SEL_LO, {24'h0, codes[i]});
      closed[0] <= 1'b1;
      settle;
      `CHK("closed", (i < 17) ? 17'h1 << i : ecx[i - 17], fv)
      closed[0] <= 1'b0;
      settle;
      `CHK("open", (i < 17) ? 17'h0 : eox[i - 17], fv)
    end
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, DIF_OFS_SEL_LO, {24'h0, 8'h45 + 8'(k)});
      closed[0] <= 1'b1;
      settle;
      `CHK("brake source", 2'(k), DC_BRAKE_SOURCE)
      closed[0] <= 1'b0;
    end
  endtask : t_codes
  task t_latch;
    logic [3:0] pats [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    logic [1:0] exp2 [4] = '{2'b01, 2'b00, 2'b11, 2'b00};
    bus(1'b1, DIF_OFS_SEL_LO, 32'h1b1a_1716);
    for (int i = 0; i < 4; i++) begin
      closed <= {2'b00, pats[i]};
      settle;
      closed <= 6'h0;
      settle;
      `CHK("latches", exp2[i], {LATCH_TWO, LATCH_ONE})
    end
  endtask : t_latch
  task t_alarm_or;
    bus(1'b1, DIF_OFS_SEL_LO, 32'h0001_0015);
    closed <= 6'b100001;
    settle;
    `CHK("alarm idle", 1'b0, ALARM_CLEAR)
    `CHK("shared code", 1'b1, EMERGENCY_STOP)
    ALARM_PENDING <= 1'b1;
    repeat (3) @(posedge CLK);
    `CHK("alarm clear", 1'b1, ALARM_CLEAR)
    ALARM_PENDING <= 1'b0;
    closed <= 6'h0;
  endtask : t_alarm_or
  task t_panel;
    bus(1'b1, DIF_OFS_SEL_LO, 32'h0000_4f4e);
    closed <= 6'b000011;
    settle;
    `CHK("panel off", 2'b00, {PANEL_FREQ_UP, PANEL_FREQ_DOWN})
    bus(1'b1, DIF_OFS_CTRL, {DIF_RST_TIMER_PERIOD, 8'h00, DIF_PANEL_FREQ_SRC});
    repeat (3) @(posedge CLK);
    `CHK("panel on", 2'b11, {PANEL_FREQ_UP, PANEL_FREQ_DOWN})
    closed <= 6'h0;
  endtask : t_panel
  task t_updown;
    bus(1'b1, DIF_OFS_LIMITS, 32'h0005_1770);
    bus(1'b1, DIF_OFS_SEL_LO, 32'h1114_0f10);
    closed <= 6'b000001;
    settle;
    `CHK("ud load", 16'h1770, UD_COUNT)
    closed <= 6'b001100;
    settle;
    `CHK("ud hold", 16'h1770, UD_COUNT)
    closed <= 6'b000100;
    settle;
    `CHK("ud down", 1'b1, UD_COUNT < 16'h1770)
    closed <= 6'b000010;
    settle;
    `CHK("ud clear", 16'h0005, UD_COUNT)
    bus(1'b0, DIF_OFS_STATUS, 32'h0);
    `CHK("status", {16'h0005, 6'h02}, {rd[DIF_STATUS_UD_LSB +: 16], rd[5:0]})
    closed <= 6'h0;
  endtask : t_updown
  // default period of ten base ticks keeps the off-delay well past one settle
  task t_timer;
    bus(1'b1, DIF_OFS_SEL_LO, 32'h0000_0007);
    closed[0] <= 1'b1;
    settle;
    `CHK("timer on", 1'b1, TIMER_OUTPUT)
    closed[0] <= 1'b0;
    settle;
    `CHK("timer delay", 1'b1, TIMER_OUTPUT)
    repeat (100) @(posedge CLK);
    `CHK("timer off", 1'b0, TIMER_OUTPUT)
  endtask : t_timer
  // inverted trigger, a period scaled by two, then input-two edges as time base
  task t_timer_ext;
    bus(1'b1, DIF_OFS_SEL_LO, 32'h0000_005b);
    repeat (3) @(posedge CLK);
    `CHK("timer inverted", 1'b1, TIMER_OUTPUT)
    ANALOG_INPUT_TWO <= 8'h02;
    bus(1'b1, DIF_OFS_SEL_LO, 32'h0000_005e);
    repeat (120) @(posedge CLK);
    `CHK("scaled hold", 1'b1, TIMER_OUTPUT)
    repeat (60) @(posedge CLK);
    `CHK("scaled off", 1'b0, TIMER_OUTPUT)
    bus(1'b1, DIF_OFS_SEL_LO, 32'h0000_1c07);
    closed <= 6'h01;
    settle;
    closed <= 6'h00;
    repeat (200) @(posedge CLK);
    `CHK("counter hold", 1'b1, TIMER_OUTPUT)
    repeat (10) begin
      closed[1] <= 1'b1;
      settle;
      closed[1] <= 1'b0;
      settle;
    end
    `CHK("counter off", 1'b0, TIMER_OUTPUT)
  endtask : t_timer_ext
  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_regs;
    t_codes;
    t_latch;
    t_alarm_or;
    t_panel;
    t_updown;
    t_timer;
    t_timer_ext;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    final_report;
  end
endmodule : testbench
